// *** src/co2rb_pkg.sv ***
package co2rb_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_RESET_CMD = 8'h00;
   localparam logic [7:0] OFF_MODE_SETTING = 8'h01;
   localparam logic [7:0] OFF_STATUS_FLAGS = 8'h02;
   localparam logic [7:0] OFF_CONC_LOW = 8'h03;
   localparam logic [7:0] OFF_CONC_HIGH = 8'h04;
   localparam logic [7:0] OFF_PRESSURE_SETTING = 8'h09;
   localparam logic [7:0] OFF_ALTITUDE_SETTING = 8'h0A;
   localparam logic [7:0] OFF_ALARM_UPPER_LIMIT = 8'h0C;
   localparam logic [7:0] OFF_ALARM_LOWER_LIMIT = 8'h0D;
   localparam logic [7:0] OFF_ADJUST_TRIGGER = 8'h0E;
   localparam logic [7:0] OFF_OUTPUT_OPTIONS = 8'h0F;
   localparam logic [7:0] OFF_SELF_CHECK = 8'h10;
   localparam logic [7:0] OFF_ADJUST_TARGET_PPM = 8'h12;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SOFT_RESET_BIT = 0;
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_ALARM_BIT = 6;
   localparam int ST_ADDR_SEL_BIT = 1;
   localparam int ST_IF_SEL_BIT = 0;
   localparam int ADJ_ZERO_BIT = 1;
   localparam int ADJ_AIR_BIT = 0;
   localparam int OPT_PULSE_EN_BIT = 0;
   localparam int OPT_COMP_EN_BIT = 2;
   localparam int OPT_RANGE_SEL_BIT = 3;
   localparam int SELF_CHECK_FLAG_BIT = 0;

   // ------------------------------------------------------------
   // nonvolatile slots and their defaults
   // ------------------------------------------------------------
   localparam int NV_SLOTS = 8;
   localparam logic [2:0] SLOT_MODE = 3'h0;
   localparam logic [2:0] SLOT_PRESSURE = 3'h1;
   localparam logic [2:0] SLOT_ALTITUDE = 3'h2;
   localparam logic [2:0] SLOT_UPPER = 3'h3;
   localparam logic [2:0] SLOT_LOWER = 3'h4;
   localparam logic [2:0] SLOT_OPTIONS = 3'h5;
   localparam logic [2:0] SLOT_TARGET = 3'h6;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_PRESSURE = 8'h00;
   localparam logic [7:0] RST_ALTITUDE = 8'h00;
   // 1000 ppm and 900 ppm at 10 ppm a step: 100 ppm apart
   localparam logic [7:0] RST_UPPER = 8'h64;
   localparam logic [7:0] RST_LOWER = 8'h5A;
   localparam logic [7:0] RST_OPTIONS = 8'h00;
   // 400 ppm at 10 ppm a step
   localparam logic [7:0] RST_TARGET = 8'h28;
   localparam logic [7:0] RST_SPARE = 8'h00;

   // ------------------------------------------------------------
   // values and scales
   // ------------------------------------------------------------
   localparam logic [7:0] MODE_CONTINUOUS = 8'h06;
   localparam logic [14:0] LIMIT_STEP_PPM = 15'h000A;
   localparam logic [14:0] CONC_MAX_PPM = 15'h2710;
   localparam logic [14:0] PULSE_FULL_SCALE_PPM = 15'h1388;

endpackage : co2rb_pkg

// *** src/co2rb_nv_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// carrier between the register bank and its nonvolatile store
interface co2rb_nv_if;
   logic wr_en;
   logic [2:0] wr_slot;
   logic [7:0] wr_data;
   logic [2:0] rd_slot;
   logic [7:0] rd_data;
   logic [7:0][7:0] vals;

   modport bank (output wr_en, output wr_slot, output wr_data, output rd_slot,
                 input rd_data, input vals);
   modport store (input wr_en, input wr_slot, input wr_data, input rd_slot,
                  output rd_data, output vals);
endinterface : co2rb_nv_if

`default_nettype wire

// *** src/co2rb_nvstore.sv ***
`timescale 1ns/1ps
`default_nettype none

module co2rb_nvstore (
   // clock and power-on reset
   input wire logic mclk,
   input wire logic sys_rst,
   // store side of the carrier
   co2rb_nv_if.store nv
);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [7:0][7:0] mem_r;

   // power-on reload only; soft reset never reaches here
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mem_r <= {co2rb_pkg::RST_SPARE, co2rb_pkg::RST_TARGET, co2rb_pkg::RST_OPTIONS,
                   co2rb_pkg::RST_LOWER, co2rb_pkg::RST_UPPER, co2rb_pkg::RST_ALTITUDE,
                   co2rb_pkg::RST_PRESSURE, co2rb_pkg::RST_MODE};
      end else if (nv.wr_en) begin
         mem_r[nv.wr_slot] <= nv.wr_data;
      end
   end

   // registered read port
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         nv.rd_data <= 8'h00;
      end else begin
         nv.rd_data <= mem_r[nv.rd_slot];
      end
   end

   // all slots visible to the control logic
   assign nv.vals = mem_r;

endmodule : co2rb_nvstore

`default_nettype wire

// *** src/co2rb_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module co2rb_sync (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // asynchronous pin and its filtered level
   input wire logic pin_in,
   output logic level_out
);

   // ------------------------------------------------------------
   // three stages; a change counts once stages two and three agree
   // ------------------------------------------------------------
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // shift chain; s1_r feeds only s2_r
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // accept the level only when two samples match
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         level_out <= 1'b0;
      end else if (s2_r == s3_r) begin
         level_out <= s3_r;
      end
   end

endmodule : co2rb_sync

`default_nettype wire

// *** src/co2rb_top.sv ***
// Contract
// (RULE_01) Concentration is read-only, 15 bits, low byte at 03H and bits 14..8 at 04H.
// (RULE_02) Status at 02H shows busy, alarm, address-select pin and interface-select pin.
// (RULE_03) A host-writable nonvolatile upper alarm threshold lives at 0CH.
// (RULE_04) A host-writable nonvolatile lower alarm threshold lives at 0DH.
// (RULE_05) The alarm switches with hysteresis between the two limits, 100 ppm by default.
// (RULE_06) Writing 0EH starts user adjustment: bit 1 zero, bit 0 fresh air.
// (RULE_07) The adjustment reference sits nonvolatile at 12H and defaults to 400 ppm.
// (RULE_08) At 0FH bit 0 enables the pulse output, bit 2 compensation, bit 3 pulse range.
// (RULE_09) Pressure at 09H and altitude at 0AH are stored nonvolatile for compensation.
// (RULE_10) Bit 0 of read-only 10H gives the self-diagnosis result, other bits zero.
// (RULE_11) The reported concentration spans 0 to 10000 ppm.
// (RULE_12) The pulse output level saturates at 5000 ppm.
// (RULE_13) Writing 06H to the mode register at 01H selects continuous measurement.
// (RULE_14) The host reads the concentration as two bytes starting at 03H.
// (RULE_15) Writing one to bit 0 of 00H soft-resets the module like power-on.
// (RULE_16) Nonvolatile registers survive soft reset; volatile ones return to defaults.
`timescale 1ns/1ps
`default_nettype none

module co2rb_top (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // register port from the host link
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // measurement engine, same clock
   input wire logic meas_busy,
   input wire logic [14:0] conc_in,
   input wire logic conc_in_valid,
   input wire logic self_check_fault,
   input wire logic adjust_done,
   // strap pins, asynchronous
   input wire logic addr_select_pin,
   input wire logic interface_select_pin,
   // controls toward the rest of the module
   output logic run_continuous,
   output logic alarm_out,
   output logic pulse_output_enable,
   output logic pulse_output_range_sel,
   output logic compensation_enable,
   output logic [12:0] pulse_level,
   output logic [7:0] pressure_out,
   output logic [7:0] altitude_out,
   output logic [7:0] adjust_target_out,
   output logic zero_adj_req,
   output logic air_adj_req,
   output logic soft_reset_pulse
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   co2rb_nv_if nv ();
   logic addr_sel_lvl;
   logic if_sel_lvl;
   logic soft_rst_r;
   logic vol_rst;
   logic [14:0] conc_r;
   logic alarm_r;
   logic [1:0] adj_r;
   logic [1:0] adj_nxt;
   logic self_check_r;
   logic rd_pend_r;
   logic [7:0] rd_addr_r;
   logic nv_hit;
   logic [2:0] nv_slot;
   logic [7:0] rdata_nxt;
   logic [14:0] upper_ppm;
   logic [14:0] lower_ppm;
   logic [7:0] opt;

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   co2rb_nvstore u_store (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .nv(nv.store)
   );

   // (RULE_02) strap pin capture
   co2rb_sync u_sync_addr (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin_in(addr_select_pin),
      .level_out(addr_sel_lvl)
   );

   co2rb_sync u_sync_if (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin_in(interface_select_pin),
      .level_out(if_sel_lvl)
   );

   // ------------------------------------------------------------
   // address decode for the nonvolatile registers
   // ------------------------------------------------------------
   // (RULE_03) (RULE_04) nonvolatile map
   always_comb begin
      nv_hit = 1'b1;
      nv_slot = co2rb_pkg::SLOT_MODE;
      case (reg_addr)
         co2rb_pkg::OFF_MODE_SETTING: nv_slot = co2rb_pkg::SLOT_MODE;
         co2rb_pkg::OFF_PRESSURE_SETTING: nv_slot = co2rb_pkg::SLOT_PRESSURE;
         co2rb_pkg::OFF_ALTITUDE_SETTING: nv_slot = co2rb_pkg::SLOT_ALTITUDE;
         co2rb_pkg::OFF_ALARM_UPPER_LIMIT: nv_slot = co2rb_pkg::SLOT_UPPER;
         co2rb_pkg::OFF_ALARM_LOWER_LIMIT: nv_slot = co2rb_pkg::SLOT_LOWER;
         co2rb_pkg::OFF_OUTPUT_OPTIONS: nv_slot = co2rb_pkg::SLOT_OPTIONS;
         co2rb_pkg::OFF_ADJUST_TARGET_PPM: nv_slot = co2rb_pkg::SLOT_TARGET;
         default: nv_hit = 1'b0;
      endcase
   end

   // (RULE_09) host writes land in the store
   assign nv.wr_en = reg_wr && nv_hit;
   assign nv.wr_slot = nv_slot;
   assign nv.wr_data = reg_wdata;
   assign nv.rd_slot = nv_slot;

   // ------------------------------------------------------------
   // soft reset
   // ------------------------------------------------------------
   // (RULE_15) one-cycle reset of volatile state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= reg_wr && (reg_addr == co2rb_pkg::OFF_RESET_CMD)
                       && reg_wdata[co2rb_pkg::SOFT_RESET_BIT];
      end
   end

   // (RULE_16) store ignores this, volatile state does not
   assign vol_rst = sys_rst || soft_rst_r;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= soft_rst_r;
      end
   end

   // ------------------------------------------------------------
   // concentration capture
   // ------------------------------------------------------------
   // (RULE_11) clip to the reportable span
   always_ff @(posedge mclk) begin
      if (vol_rst) begin
         conc_r <= 15'h0000;
      end else if (conc_in_valid) begin
         conc_r <= (conc_in > co2rb_pkg::CONC_MAX_PPM) ? co2rb_pkg::CONC_MAX_PPM : conc_in;
      end
   end

   // ------------------------------------------------------------
   // alarm with hysteresis
   // ------------------------------------------------------------
   // limits are 8-bit steps, scaled up to ppm
   assign upper_ppm = 15'(nv.vals[co2rb_pkg::SLOT_UPPER]) * co2rb_pkg::LIMIT_STEP_PPM;
   assign lower_ppm = 15'(nv.vals[co2rb_pkg::SLOT_LOWER]) * co2rb_pkg::LIMIT_STEP_PPM;

   // (RULE_05) set at upper, release below lower
   always_ff @(posedge mclk) begin
      if (vol_rst) begin
         alarm_r <= 1'b0;
      end else if (conc_r >= upper_ppm) begin
         alarm_r <= 1'b1;
      end else if (conc_r < lower_ppm) begin
         alarm_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         alarm_out <= 1'b0;
      end else begin
         alarm_out <= alarm_r;
      end
   end

   // ------------------------------------------------------------
   // user adjustment requests
   // ------------------------------------------------------------
   // (RULE_06) host sets, done clears; a set in the same cycle wins
   always_comb begin
      adj_nxt = adj_r;
      if (adjust_done) begin
         adj_nxt = 2'b00;
      end
      if (reg_wr && (reg_addr == co2rb_pkg::OFF_ADJUST_TRIGGER)) begin
         adj_nxt = adj_nxt | reg_wdata[co2rb_pkg::ADJ_ZERO_BIT:co2rb_pkg::ADJ_AIR_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (vol_rst) begin
         adj_r <= 2'b00;
      end else begin
         adj_r <= adj_nxt;
      end
   end

   // held as levels so the engine cannot miss one
   always_ff @(posedge mclk) begin
      if (vol_rst) begin
         zero_adj_req <= 1'b0;
         air_adj_req <= 1'b0;
      end else begin
         zero_adj_req <= adj_r[co2rb_pkg::ADJ_ZERO_BIT];
         air_adj_req <= adj_r[co2rb_pkg::ADJ_AIR_BIT];
      end
   end

   // ------------------------------------------------------------
   // self diagnosis
   // ------------------------------------------------------------
   // (RULE_10) fault flag follows the engine
   always_ff @(posedge mclk) begin
      if (vol_rst) begin
         self_check_r <= 1'b0;
      end else begin
         self_check_r <= self_check_fault;
      end
   end

   // ------------------------------------------------------------
   // control outputs from stored settings
   // ------------------------------------------------------------
   assign opt = nv.vals[co2rb_pkg::SLOT_OPTIONS];

   // (RULE_08) (RULE_13) (RULE_07) mirror the store into flops
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         run_continuous <= 1'b0;
         pulse_output_enable <= 1'b0;
         pulse_output_range_sel <= 1'b0;
         compensation_enable <= 1'b0;
         pressure_out <= 8'h00;
         altitude_out <= 8'h00;
         adjust_target_out <= 8'h00;
      end else begin
         run_continuous <= nv.vals[co2rb_pkg::SLOT_MODE] == co2rb_pkg::MODE_CONTINUOUS;
         pulse_output_enable <= opt[co2rb_pkg::OPT_PULSE_EN_BIT];
         pulse_output_range_sel <= opt[co2rb_pkg::OPT_RANGE_SEL_BIT];
         compensation_enable <= opt[co2rb_pkg::OPT_COMP_EN_BIT];
         pressure_out <= nv.vals[co2rb_pkg::SLOT_PRESSURE];
         altitude_out <= nv.vals[co2rb_pkg::SLOT_ALTITUDE];
         adjust_target_out <= nv.vals[co2rb_pkg::SLOT_TARGET];
      end
   end

   // (RULE_12) pulse level clipped at full scale, zero when disabled
   always_ff @(posedge mclk) begin
      if (vol_rst) begin
         pulse_level <= 13'h0000;
      end else if (!opt[co2rb_pkg::OPT_PULSE_EN_BIT]) begin
         pulse_level <= 13'h0000;
      end else if (conc_r > co2rb_pkg::PULSE_FULL_SCALE_PPM) begin
         pulse_level <= co2rb_pkg::PULSE_FULL_SCALE_PPM[12:0];
      end else begin
         pulse_level <= conc_r[12:0];
      end
   end

   // ------------------------------------------------------------
   // read path: address at edge 1, data at edge 2
   // ------------------------------------------------------------
   // the extra stage lets the store keep a registered read port
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= 8'h00;
      end else begin
         rd_pend_r <= reg_rd;
         rd_addr_r <= reg_addr;
      end
   end

   // (RULE_01) (RULE_02) (RULE_14) read mux
   always_comb begin
      rdata_nxt = 8'h00;
      case (rd_addr_r)
         co2rb_pkg::OFF_STATUS_FLAGS: begin
            rdata_nxt[co2rb_pkg::ST_BUSY_BIT] = meas_busy;
            rdata_nxt[co2rb_pkg::ST_ALARM_BIT] = alarm_r;
            rdata_nxt[co2rb_pkg::ST_ADDR_SEL_BIT] = addr_sel_lvl;
            rdata_nxt[co2rb_pkg::ST_IF_SEL_BIT] = if_sel_lvl;
         end
         co2rb_pkg::OFF_CONC_LOW: rdata_nxt = conc_r[7:0];
         co2rb_pkg::OFF_CONC_HIGH: rdata_nxt = {1'b0, conc_r[14:8]};
         co2rb_pkg::OFF_ADJUST_TRIGGER: rdata_nxt = {6'h00, adj_r};
         co2rb_pkg::OFF_SELF_CHECK: rdata_nxt[co2rb_pkg::SELF_CHECK_FLAG_BIT] = self_check_r;
         co2rb_pkg::OFF_MODE_SETTING,
         co2rb_pkg::OFF_PRESSURE_SETTING,
         co2rb_pkg::OFF_ALTITUDE_SETTING,
         co2rb_pkg::OFF_ALARM_UPPER_LIMIT,
         co2rb_pkg::OFF_ALARM_LOWER_LIMIT,
         co2rb_pkg::OFF_OUTPUT_OPTIONS,
         co2rb_pkg::OFF_ADJUST_TARGET_PPM: rdata_nxt = nv.rd_data;
         default: rdata_nxt = 8'h00;
      endcase
   end

   // data holds until the next read completes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= rd_pend_r;
         if (rd_pend_r) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

endmodule : co2rb_top

`default_nettype wire

// *** verification/co2rb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// host side of the register port, driven on the falling edge
module co2rb_host_model (
   // clock
   input wire logic mclk,
   // register port, host side
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // idle port at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // one write; idle lines show the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   // one read, bounded wait for the valid pulse
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      for (int i = 0; i < 4; i++) begin
         @(negedge mclk);
         if (reg_rvalid === 1'b1) break;
      end
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
   endtask : rd

   task automatic read_conc(output logic [14:0] c);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(8'h03, lo);
      rd(8'h04, hi);
      c = {hi[6:0], lo};
   endtask : read_conc
endmodule : co2rb_host_model

`default_nettype wire

// *** verification/co2rb_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module co2rb_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // engine side
   input wire logic meas_busy,
   input wire logic [14:0] conc_in,
   input wire logic conc_in_valid,
   input wire logic adjust_done,
   // controls
   input wire logic run_continuous,
   input wire logic pulse_output_enable,
   input wire logic [12:0] pulse_level,
   input wire logic zero_adj_req,
   input wire logic air_adj_req,
   input wire logic soft_reset_pulse
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   // reads answer exactly two edges later
   property p_rd_lat;
      reg_rd |-> ##2 reg_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read valid late");
   property p_hi_byte;
      reg_rd && reg_addr == 8'h04 ##2 1'b1 |-> reg_rdata[7] == 1'b0;
   endproperty
   a_hi_byte: assert property (p_hi_byte) else $error("high byte bit 7 set");
   // busy is taken in the middle cycle of the read
   property p_status;
      reg_rd && reg_addr == 8'h02 ##2 1'b1
         |-> reg_rdata[5:2] == 4'h0 && reg_rdata[7] == $past(meas_busy);
   endproperty
   a_status: assert property (p_status) else $error("status bits wrong");
   property p_self;
      reg_rd && reg_addr == 8'h10 ##2 1'b1 |-> reg_rdata[7:1] == 7'h00;
   endproperty
   a_self: assert property (p_self) else $error("self check spare bits");
   property p_mode;
      reg_wr && reg_addr == 8'h01
         |-> ##2 run_continuous == ($past(reg_wdata, 2) == 8'h06);
   endproperty
   a_mode: assert property (p_mode) else $error("mode output wrong");
   property p_soft;
      reg_wr && reg_addr == 8'h00 && reg_wdata[0] |-> ##2 soft_reset_pulse ##1 !soft_reset_pulse;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
   property p_adj;
      reg_wr && reg_addr == 8'h0E && !adjust_done
         |-> ##2 (zero_adj_req || !$past(reg_wdata[1], 2)) && (air_adj_req || !$past(reg_wdata[0], 2));
   endproperty
   a_adj: assert property (p_adj) else $error("adjust request missing");
   property p_done;
      adjust_done && !(reg_wr && reg_addr == 8'h0E) |-> ##2 !zero_adj_req && !air_adj_req;
   endproperty
   a_done: assert property (p_done) else $error("adjust request not cleared");
   // clipping holds only while the output stays enabled
   property p_clip;
      conc_in_valid && pulse_output_enable ##2 pulse_output_enable
         |-> pulse_level == (($past(conc_in, 2) > 15'h1388) ? 15'h1388 : $past(conc_in, 2));
   endproperty
   a_clip: assert property (p_clip) else $error("pulse level not clipped");
   property p_off;
      !pulse_output_enable [*3] |-> pulse_level == 13'h0000;
   endproperty
   a_off: assert property (p_off) else $error("pulse level while disabled");

   // main scenarios
   c_rd: cover property (reg_rvalid);
   c_soft: cover property (soft_reset_pulse);
   c_adj: cover property (zero_adj_req && air_adj_req);
endmodule : co2rb_checker

bind co2rb_top co2rb_checker chk_u (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .reg_rvalid, .meas_busy, .conc_in, .conc_in_valid, .adjust_done,
   .run_continuous, .pulse_output_enable, .pulse_level, .zero_adj_req, .air_adj_req,
   .soft_reset_pulse);

`default_nettype wire

// *** verification/co2_sensor_register_map_test.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end

module co2_sensor_register_map_test;
   logic mclk, sys_rst, reg_wr, reg_rd, reg_rvalid, meas_busy, conc_in_valid;
   logic self_check_fault, adjust_done, addr_select_pin, interface_select_pin;
   logic run_continuous, alarm_out, pulse_output_enable, pulse_output_range_sel;
   logic compensation_enable, zero_adj_req, air_adj_req, soft_reset_pulse;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pressure_out, altitude_out, adjust_target_out, rv;
   logic [14:0] conc_in, cv;
   logic [12:0] pulse_level;
   int err_total, checks, cycles, n;

   co2rb_top dut_u (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reg_rvalid, .meas_busy, .conc_in, .conc_in_valid, .self_check_fault, .adjust_done,
      .addr_select_pin, .interface_select_pin, .run_continuous, .alarm_out,
      .pulse_output_enable, .pulse_output_range_sel, .compensation_enable, .pulse_level,
      .pressure_out, .altitude_out, .adjust_target_out, .zero_adj_req, .air_adj_req,
      .soft_reset_pulse);

   co2rb_host_model host_u (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reg_rvalid);

   // 50 ns clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         test_done();
      end
   end

   task test_done;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // read and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, rv);
      `CHK($sformatf("reg %h", a), e, rv)
   endtask : rchk

   // write, then let the mirrored outputs land
   task automatic wset(input logic [7:0] a, input logic [7:0] d);
      host_u.wr(a, d);
      repeat (2) @(negedge mclk);
   endtask : wset

   // one capture, then wait for the alarm output
   task automatic meas(input logic [14:0] v);
      @(negedge mclk);
      conc_in = v;
      conc_in_valid = 1'b1;
      @(negedge mclk);
      conc_in_valid = 1'b0;
      repeat (3) @(negedge mclk);
   endtask : meas

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {sys_rst, addr_select_pin} = 2'b11;
      {meas_busy, conc_in_valid, self_check_fault, adjust_done, interface_select_pin} = 5'h00;
      conc_in = 15'h0000;
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (6) @(negedge mclk);
      `CHK("target out", 8'h28, adjust_target_out)
      rchk(8'h12, 8'h28);
      rchk(8'h0C, 8'h64);
      rchk(8'h0D, 8'h5A);
      rchk(8'h01, 8'h00);
      rchk(8'h0F, 8'h00);
      rchk(8'h00, 8'h00);
      rchk(8'h05, 8'h00);
      wset(8'h09, 8'hA5);
      `CHK("pressure", 8'hA5, pressure_out)
      wset(8'h0A, 8'h5A);
      rchk(8'h0A, 8'h5A);
      `CHK("altitude", 8'h5A, altitude_out)
      wset(8'h12, 8'h32);
      `CHK("target", 8'h32, adjust_target_out)
      wset(8'h0F, 8'h0C);
      `CHK("options", 2'b11, {compensation_enable, pulse_output_range_sel})
      wset(8'h0F, 8'h01);
      rchk(8'h0F, 8'h01);
      `CHK("options", 3'b100, {pulse_output_enable, compensation_enable, pulse_output_range_sel})
      wset(8'h01, 8'h07);
      `CHK("run", 1'b0, run_continuous)
      wset(8'h01, 8'h06);
      `CHK("run", 1'b1, run_continuous)
      // concentration pairing, clipping and a refused write
      meas(15'h0659);
      host_u.read_conc(cv);
      `CHK("conc", 15'h0659, cv)
      `CHK("pulse", 13'h0659, pulse_level)
      meas(15'h2EE0);
      host_u.read_conc(cv);
      `CHK("conc", 15'h2710, cv)
      `CHK("pulse", 13'h1388, pulse_level)
      wset(8'h03, 8'h00);
      rchk(8'h03, 8'h10);
      // alarm hysteresis at the default and at written limits
      meas(15'h0000);
      meas(15'h03E8);
      `CHK("alarm", 1'b1, alarm_out)
      meas(15'h0384);
      meas_busy = 1'b1;
      rchk(8'h02, 8'hC2);
      meas_busy = 1'b0;
      meas(15'h0383);
      `CHK("alarm", 1'b0, alarm_out)
      meas(15'h0096);
      wset(8'h0C, 8'h14);
      wset(8'h0D, 8'h0A);
      `CHK("alarm", 1'b0, alarm_out)
      meas(15'h00C8);
      `CHK("alarm", 1'b1, alarm_out)
      meas(15'h0064);
      `CHK("alarm", 1'b1, alarm_out)
      meas(15'h0063);
      `CHK("alarm", 1'b0, alarm_out)
      {self_check_fault, addr_select_pin, interface_select_pin} = 3'b101;
      rchk(8'h10, 8'h01);
      self_check_fault = 1'b0;
      rchk(8'h10, 8'h00);
      rchk(8'h02, 8'h01);
      // adjustment request and its clearing
      wset(8'h0E, 8'h03);
      `CHK("adjust", 2'b11, {zero_adj_req, air_adj_req})
      rchk(8'h0E, 8'h03);
      adjust_done = 1'b1;
      @(negedge mclk);
      adjust_done = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK("adjust", 2'b00, {zero_adj_req, air_adj_req})
      wset(8'h0E, 8'h02);
      `CHK("adjust", 2'b10, {zero_adj_req, air_adj_req})
      // soft reset keeps stored settings, clears volatile state
      wset(8'h09, 8'h33);
      host_u.wr(8'h00, 8'h01);
      n = 0;
      repeat (4) begin
         @(negedge mclk);
         if (soft_reset_pulse === 1'b1) n++;
      end
      `CHK("soft pulses", 1, n)
      `CHK("adjust", 2'b00, {zero_adj_req, air_adj_req})
      rchk(8'h03, 8'h00);
      rchk(8'h09, 8'h33);
      `CHK("run", 1'b1, run_continuous)
      // power-on reset reloads defaults
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      rchk(8'h09, 8'h00);
      test_done();
   end
endmodule : co2_sensor_register_map_test

`default_nettype wire
